//--- rtl/lffc_core.sv
// lffc_core: flash/torch mode sequencer with protection, fault flags and
// register file. analog comparator levels arrive asynchronously; the
// register port is driven by the serial slave on the same clock.
`timescale 1ns/1ps
// Operation
// - stay in pass mode until headroom falls below threshold, then boost
// - sync input high during flash drives torch level
// - sync input low again restores the previous flash level
// - time-out turns current off whatever the sync input does
// - sync enable bit zero ignores the sync input
// - monitor threshold from bits 4:3, hysteresis from bits 2:1
// - monitor flag set on threshold crossing during flash in every monitor mode except off
// - stop-and-hold mode freezes ramp on crossing for the flash
// - down mode steps down below threshold, never back up this flash
// - up-down mode steps down below threshold, up above hysteresis
// - fault sets flag, clears and locks torch enable and mode bits
// - eight time-outs 50 ms to 400 ms from duration bits 2:0
// - overvoltage must persist 512 us before flag and mode clear
// - current limit select from enable bits 7:5
// - current limit event sets flag bit 4, mode untouched
// - thermistor detection only while lit; trip cuts current, flags
// - thermistor short/open flags, each with its own enable, disable
// - low supply lockout flags, clears mode, holds until flags1 read
// - thermal shutdown flags, standby, re-flags after read if hot
// - led and output shorts flagged while lit, cleared only by read
// - led short sampled 256 us, output short 2.048 ms after start
// - mode 00/01 standby, 10 torch, 11 flash
module lffc_core
  import lffc_pkg::*;
#(
  parameter int TIMEOUT_STEP_CYC = (TIMEOUT_STEP_US * 1000) / CLK_PERIOD_NS,
  parameter int OVP_CYC = (OVP_DEGLITCH_US * 1000) / CLK_PERIOD_NS,
  parameter int VOUT_SAMPLE_CYC = VOUT_SAMPLE_NS / CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rd_done,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [LEVEL_W-1:0] flash_target,
  input wire logic sync_pin,
  input wire logic headroom_low,
  input wire logic vin_below_thr,
  input wire logic vin_above_hys,
  input wire logic ovp_cmp,
  input wire logic ilim_cmp,
  input wire logic therm_trip_cmp,
  input wire logic therm_short_cmp,
  input wire logic therm_open_cmp,
  input wire logic low_supply_lockout_cmp,
  input wire logic tsd_cmp,
  input wire logic led1_short_cmp,
  input wire logic led2_short_cmp,
  input wire logic vout_short_cmp,
  output logic boost_mode,
  output logic led_on,
  output logic [LEVEL_W-1:0] led_level,
  output logic flash_active,
  output logic torch_active,
  output logic therm_detect_on,
  output logic [2:0] ilim_sel,
  output logic [1:0] monitor_thr_sel,
  output logic [1:0] monitor_hys_sel
);

  // pin synchroniser; stage one is read only by stage two
  logic [N_SYNC-1:0] sync_a;
  logic [N_SYNC-1:0] s;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_a <= '0;
      s <= '0;
    end else begin
      sync_a <= {vout_short_cmp, led2_short_cmp, led1_short_cmp, tsd_cmp, low_supply_lockout_cmp,
                 therm_open_cmp, therm_short_cmp, therm_trip_cmp, ilim_cmp, ovp_cmp,
                 vin_above_hys, vin_below_thr, headroom_low, sync_pin};
      s <= sync_a;
    end
  end

  logic [7:0] enable_reg;
  logic [7:0] monitor_reg;
  logic [7:0] therm_ramp_reg;
  logic [7:0] duration_reg;
  logic [7:0] torch_reg;
  logic [7:0] flags1;
  logic [3:0] flags2;
  logic short_en;
  logic fault_lock;
  logic low_supply_lockout_lock;
  logic act_q;
  logic [19:0] since_start;
  logic [19:0] ovp_cnt;
  logic [19:0] tmo_pre;
  logic [3:0] tmo_steps;
  logic [7:0] ramp_cnt;
  logic [LEVEL_W-1:0] flash_lvl;
  logic hold;
  logic no_up;
  logic dn_act;

  // decode
  wire wr_en = reg_wr && reg_addr == ADDR_ENABLE;
  wire wr_mon = reg_wr && reg_addr == ADDR_MONITOR;
  wire wr_tr = reg_wr && reg_addr == ADDR_THERM_RAMP;
  wire wr_dur = reg_wr && reg_addr == ADDR_DURATION;
  wire wr_torch = reg_wr && reg_addr == ADDR_TORCH;
  wire wr_f2 = reg_wr && reg_addr == ADDR_FLAGS2;
  wire rd1_done = reg_rd_done && reg_addr == ADDR_FLAGS1;
  wire rd2_done = reg_rd_done && reg_addr == ADDR_FLAGS2;
  wire locked = fault_lock || low_supply_lockout_lock;

  wire [1:0] mode = enable_reg[EN_MODE_HI:EN_MODE_LO];
  wire flash_run = mode == LFFC_FLASH;
  wire torch_run = !flash_run && (mode == LFFC_TORCH || torch_reg[TORCH_EN]);
  wire lit = flash_run || torch_run;
  wire start = lit && !act_q;
  wire [1:0] mon_mode = monitor_reg[MON_MODE_HI:MON_MODE_LO];

  wire sync_eff = enable_reg[EN_SYNC] && s[S_SYNC];

  // eight durations, select+1 steps of 50 ms
  wire [3:0] tmo_limit = {1'b0, duration_reg[DUR_SEL_HI:DUR_SEL_LO]} + 4'h1;
  wire tmo_tick = tmo_pre == 20'(TIMEOUT_STEP_CYC - 1);
  wire tmo_exp = flash_run && tmo_tick && (tmo_steps + 4'h1) == tmo_limit;

  wire ovp_ev = s[S_OVP] && ovp_cnt == 20'(OVP_CYC - 1);
  // detection only while lit and enabled
  wire therm_on = lit && enable_reg[EN_THERM];
  wire trip_ev = therm_on && s[S_TRIP];
  wire tshort_ev = therm_on && short_en && s[S_TSHORT];
  wire topen_ev = therm_on && monitor_reg[MON_OPEN_EN] && s[S_TOPEN];
  wire low_supply_lockout_ev = monitor_reg[MON_LOW_SUPPLY_LOCKOUT_EN] && s[S_LOW_SUPPLY_LOCKOUT];
  // level re-flags after clear while still hot
  wire tsd_ev = s[S_TSD];
  wire led_pt = lit && since_start == 20'(LED_SAMPLE_CYC);
  wire vout_pt = lit && since_start == 20'(VOUT_SAMPLE_CYC);
  wire led1_ev = led_pt && s[S_LED1];
  wire led2_ev = led_pt && s[S_LED2];
  wire vout_ev = vout_pt && s[S_VOUT];
  // no mode clear on current limit
  wire ocp_ev = s[S_ILIM];
  // crossing seen in any active monitor mode
  wire mon_ev = flash_run && mon_mode != LFFC_MON_OFF && s[S_BELOW];

  // faults that lock the mode bits
  wire fault_ev = ovp_ev || trip_ev || tshort_ev || topen_ev || low_supply_lockout_ev || tsd_ev ||
                  led1_ev || led2_ev || vout_ev;
  wire clr_mode = fault_ev || tmo_exp || locked;

  wire [7:0] f1_set = {ovp_ev, trip_ev, tsd_ev, ocp_ev, mon_ev, low_supply_lockout_ev, vout_ev, tmo_exp};
  wire [3:0] f2_set = {led2_ev, led1_ev, tshort_ev, topen_ev};
  wire [7:0] next_flags1 = (rd1_done ? 8'h00 : flags1) | f1_set;
  wire [3:0] next_flags2 = (rd2_done ? 4'h0 : flags2) | f2_set;

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_reg <= RST_ENABLE;
      monitor_reg <= RST_MONITOR;
      therm_ramp_reg <= RST_THERM_RAMP;
      duration_reg <= RST_DURATION;
      torch_reg <= RST_TORCH;
      short_en <= RST_FLAGS2_CFG[F2_SHORT_EN];
    end else begin
      if (wr_en) begin
        enable_reg <= reg_wdata;
      end
      // mode and torch enable held clear while locked
      if (clr_mode) begin
        enable_reg[EN_MODE_HI:EN_MODE_LO] <= LFFC_STANDBY0;
        torch_reg[TORCH_EN] <= 1'b0;
      end
      if (wr_torch) begin
        torch_reg <= {reg_wdata[TORCH_EN] && !clr_mode, reg_wdata[TORCH_EN-1:0]};
      end
      if (wr_mon) begin
        monitor_reg <= reg_wdata;
      end
      if (wr_tr) begin
        therm_ramp_reg <= reg_wdata;
      end
      if (wr_dur) begin
        duration_reg <= reg_wdata;
      end
      if (wr_f2) begin
        short_en <= reg_wdata[F2_SHORT_EN];
      end
    end
  end

  // flags and lock; a new event wins over a read clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags1 <= 8'h00;
      flags2 <= 4'h0;
      fault_lock <= 1'b0;
      low_supply_lockout_lock <= 1'b0;
    end else begin
      flags1 <= next_flags1;
      flags2 <= next_flags2;
      fault_lock <= fault_ev || (fault_lock && !(rd1_done || rd2_done));
      // only a flags1 read releases lockout
      low_supply_lockout_lock <= low_supply_lockout_ev || (low_supply_lockout_lock && !rd1_done);
    end
  end

  // read data, captured when the read begins
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      ADDR_ENABLE: rd_mux = enable_reg;
      ADDR_MONITOR: rd_mux = monitor_reg;
      ADDR_THERM_RAMP: rd_mux = therm_ramp_reg;
      ADDR_DURATION: rd_mux = duration_reg;
      ADDR_TORCH: rd_mux = torch_reg;
      ADDR_FLAGS1: rd_mux = flags1;
      ADDR_FLAGS2: rd_mux = {2'b00, RST_FLAGS2_CFG[F2_CFG_HI], short_en, flags2};
      default: rd_mux = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // timers: start-relative sample counter, deglitch, time-out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act_q <= 1'b0;
      since_start <= '0;
      ovp_cnt <= '0;
      tmo_pre <= '0;
      tmo_steps <= '0;
    end else begin
      act_q <= lit;
      if (start || !lit) begin
        since_start <= '0;
      end else if (since_start != 20'(VOUT_SAMPLE_CYC + 1)) begin
        since_start <= since_start + 20'h1;
      end
      ovp_cnt <= (s[S_OVP] && !ovp_ev) ? ovp_cnt + 20'h1 : 20'h0;
      if (!flash_run) begin
        tmo_pre <= '0;
        tmo_steps <= '0;
      end else if (tmo_tick) begin
        tmo_pre <= '0;
        tmo_steps <= tmo_steps + 4'h1;
      end else begin
        tmo_pre <= tmo_pre + 20'h1;
      end
    end
  end

  // flash level stepping under the input monitor
  wire ramp_tick = ramp_cnt == 8'(RAMP_STEP_CYC - 1);
  wire below = s[S_BELOW];
  wire above = s[S_ABOVE_HYS];
  logic [LEVEL_W-1:0] next_flash_lvl;
  logic next_dn;
  always_comb begin
    next_flash_lvl = flash_lvl;
    next_dn = dn_act;
    if (below) begin
      next_dn = 1'b1;
    end else if (above) begin
      next_dn = 1'b0;
    end
    unique case (mon_mode)
      LFFC_MON_HOLD: begin
        if (!hold && !below && flash_lvl < flash_target) begin
          next_flash_lvl = flash_lvl + LEVEL_W'(1);
        end
      end
      // down only after the first crossing
      LFFC_MON_DOWN: begin
        if (dn_act && flash_lvl != '0) begin
          next_flash_lvl = flash_lvl - LEVEL_W'(1);
        end else if (!no_up && !dn_act && flash_lvl < flash_target) begin
          next_flash_lvl = flash_lvl + LEVEL_W'(1);
        end
      end
      LFFC_MON_UPDN: begin
        if (dn_act && flash_lvl != '0) begin
          next_flash_lvl = flash_lvl - LEVEL_W'(1);
        end else if (!dn_act && flash_lvl < flash_target) begin
          next_flash_lvl = flash_lvl + LEVEL_W'(1);
        end
      end
      LFFC_MON_OFF: begin
        if (flash_lvl < flash_target) begin
          next_flash_lvl = flash_lvl + LEVEL_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ramp_cnt <= '0;
      flash_lvl <= '0;
      hold <= 1'b0;
      no_up <= 1'b0;
      dn_act <= 1'b0;
    end else if (!flash_run) begin
      ramp_cnt <= '0;
      flash_lvl <= '0;
      hold <= 1'b0;
      no_up <= 1'b0;
      dn_act <= 1'b0;
    end else begin
      ramp_cnt <= ramp_tick ? 8'h00 : ramp_cnt + 8'h01;
      hold <= hold || below;
      no_up <= no_up || below;
      dn_act <= next_dn;
      // level tracked even while sync holds torch, so it can be restored
      if (ramp_tick) begin
        flash_lvl <= next_flash_lvl;
      end
    end
  end

  // outputs; faults cut current in the same cycle the mode clears
  wire cut = fault_ev || tmo_exp || locked;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      boost_mode <= 1'b0;
      led_on <= 1'b0;
      led_level <= '0;
      flash_active <= 1'b0;
      torch_active <= 1'b0;
      therm_detect_on <= 1'b0;
      ilim_sel <= 3'h0;
      monitor_thr_sel <= 2'h0;
      monitor_hys_sel <= 2'h0;
    end else begin
      // pass until headroom lost, back to pass in standby
      boost_mode <= lit && (boost_mode || s[S_HEADROOM]);
      // time-out or fault turns off regardless of sync
      led_on <= lit && !cut;
      if (!lit || cut) begin
        led_level <= '0;
      end else if (flash_run && !sync_eff) begin
        // flash level restored when sync drops
        led_level <= flash_lvl;
      end else begin
        led_level <= torch_reg[LEVEL_W-1:0];
      end
      flash_active <= flash_run && !cut;
      torch_active <= torch_run && !cut;
      therm_detect_on <= therm_on;
      ilim_sel <= enable_reg[EN_ILIM_HI:EN_ILIM_LO];
      monitor_thr_sel <= monitor_reg[MON_THR_HI:MON_THR_LO];
      monitor_hys_sel <= monitor_reg[MON_HYS_HI:MON_HYS_LO];
    end
  end

endmodule // lffc_core

//--- rtl/lffc_pkg.sv
// lffc_pkg: register map, field positions, reset values and timing for the
// flash mode and fault sequencer. assumes a 10 MHz reference clock.
package lffc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_ENABLE = 8'h01;
  localparam logic [7:0] ADDR_MONITOR = 8'h02;
  localparam logic [7:0] ADDR_THERM_RAMP = 8'h03;
  localparam logic [7:0] ADDR_DURATION = 8'h04;
  localparam logic [7:0] ADDR_TORCH = 8'h07;
  localparam logic [7:0] ADDR_FLAGS1 = 8'h08;
  localparam logic [7:0] ADDR_FLAGS2 = 8'h09;
  // reset values
  localparam logic [7:0] RST_ENABLE = 8'he0;
  localparam logic [7:0] RST_MONITOR = 8'ha4;
  localparam logic [7:0] RST_THERM_RAMP = 8'h20;
  localparam logic [7:0] RST_DURATION = 8'h42;
  localparam logic [7:0] RST_TORCH = 8'h7f;
  localparam logic [7:0] RST_FLAGS2_CFG = 8'h30;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // enable register fields
  localparam int EN_ILIM_HI = 7;
  localparam int EN_ILIM_LO = 5;
  localparam int EN_THERM = 4;
  localparam int EN_SYNC = 3;
  localparam int EN_MODE_HI = 1;
  localparam int EN_MODE_LO = 0;
  // monitor register fields
  localparam int MON_LOW_SUPPLY_LOCKOUT_EN = 7;
  localparam int MON_MODE_HI = 6;
  localparam int MON_MODE_LO = 5;
  localparam int MON_THR_HI = 4;
  localparam int MON_THR_LO = 3;
  localparam int MON_HYS_HI = 2;
  localparam int MON_HYS_LO = 1;
  localparam int MON_OPEN_EN = 0;
  // duration and torch fields
  localparam int DUR_SEL_HI = 2;
  localparam int DUR_SEL_LO = 0;
  localparam int TORCH_EN = 7;
  // flags register 1
  localparam int F1_TIMEOUT = 0;
  localparam int F1_VOUT_SHORT = 1;
  localparam int F1_LOW_SUPPLY_LOCKOUT = 2;
  localparam int F1_MONITOR = 3;
  localparam int F1_OCP = 4;
  localparam int F1_TSD = 5;
  localparam int F1_THERM_TRIP = 6;
  localparam int F1_OVP = 7;
  // flags register 2
  localparam int F2_THERM_OPEN = 0;
  localparam int F2_THERM_SHORT = 1;
  localparam int F2_LED1_SHORT = 2;
  localparam int F2_LED2_SHORT = 3;
  localparam int F2_SHORT_EN = 4;
  localparam int F2_CFG_HI = 5;
  // mode codes
  typedef enum logic [1:0] {
    LFFC_STANDBY0 = 2'b00,
    LFFC_STANDBY1 = 2'b01,
    LFFC_TORCH = 2'b10,
    LFFC_FLASH = 2'b11
  } lffc_mode_t;
  typedef enum logic [1:0] {
    LFFC_MON_OFF = 2'b00,
    LFFC_MON_HOLD = 2'b01,
    LFFC_MON_DOWN = 2'b10,
    LFFC_MON_UPDN = 2'b11
  } lffc_mon_t;
  // synchronised input indices
  localparam int S_SYNC = 0;
  localparam int S_HEADROOM = 1;
  localparam int S_BELOW = 2;
  localparam int S_ABOVE_HYS = 3;
  localparam int S_OVP = 4;
  localparam int S_ILIM = 5;
  localparam int S_TRIP = 6;
  localparam int S_TSHORT = 7;
  localparam int S_TOPEN = 8;
  localparam int S_LOW_SUPPLY_LOCKOUT = 9;
  localparam int S_TSD = 10;
  localparam int S_LED1 = 11;
  localparam int S_LED2 = 12;
  localparam int S_VOUT = 13;
  localparam int N_SYNC = 14;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMEOUT_STEP_US = 50000;
  localparam int OVP_DEGLITCH_US = 512;
  localparam int LED_SAMPLE_US = 256;
  localparam int VOUT_SAMPLE_NS = 2048000;
  localparam int LED_SAMPLE_CYC = (LED_SAMPLE_US * 1000) / CLK_PERIOD_NS;
  localparam int RAMP_STEP_CYC = 16;
  localparam int LEVEL_W = 7;
endpackage

//--- verification/lffc_properties.sv
// lffc_properties: port-level checker for lffc_core, bound below.
// assumes one clock domain, synchronous active-high reset, strobes 2 cycles apart.
`timescale 1ns/1ps
module lffc_props
  import lffc_pkg::*;
#(
  parameter int TIMEOUT_STEP_CYC = 500000,
  parameter int OVP_CYC = 5120
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic headroom_low,
  input wire logic ovp_cmp,
  input wire logic tsd_cmp,
  input wire logic boost_mode,
  input wire logic led_on,
  input wire logic flash_active,
  input wire logic torch_active,
  input wire logic therm_detect_on,
  input wire logic [2:0] ilim_sel,
  input wire logic [1:0] monitor_thr_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] flash_cnt;
  logic [15:0] ovp_run;
  // run lengths; ovp count saturates so a stuck comparator cannot wrap it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_cnt <= '0;
      ovp_run <= '0;
    end else begin
      flash_cnt <= flash_active ? flash_cnt + 32'h1 : '0;
      ovp_run <= !ovp_cmp ? '0 : ((&ovp_run) ? ovp_run : ovp_run + 16'h1);
    end
  end
  chk_reset_quiet: assert property ($fell(rst) |-> !led_on && !flash_active && !boost_mode)
    else $error("outputs active after reset");
  chk_boost_cause: assert property ($rose(boost_mode) |->
    $past(headroom_low, 2) || $past(headroom_low, 3) || $past(headroom_low, 4))
    else $error("boost entered without low headroom");
  chk_ilim_copy: assert property (reg_wr && reg_addr == ADDR_ENABLE |->
    ##2 ilim_sel == $past(reg_wdata[EN_ILIM_HI:EN_ILIM_LO], 2))
    else $error("current limit select does not follow register");
  chk_monitor_copy: assert property (reg_wr && reg_addr == ADDR_MONITOR |->
    ##2 monitor_thr_sel == $past(reg_wdata[MON_THR_HI:MON_THR_LO], 2))
    else $error("monitor threshold does not follow register");
  chk_flash_bound: assert property (flash_cnt <= 8 * TIMEOUT_STEP_CYC + 4)
    else $error("flash outlived the longest time-out");
  chk_therm_dark: assert property (therm_detect_on |->
    flash_active || torch_active || $past(flash_active || torch_active))
    else $error("thermistor detection on while dark");
  chk_tsd_dark: assert property (tsd_cmp [*8] |-> !led_on)
    else $error("led lit during thermal shutdown");
  chk_ovp_persist: assert property (ovp_run >= OVP_CYC + 8 |-> !led_on)
    else $error("led lit after persistent overvoltage");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule // lffc_props

bind lffc_core lffc_props #(.TIMEOUT_STEP_CYC(TIMEOUT_STEP_CYC), .OVP_CYC(OVP_CYC)) u_props (
  .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .headroom_low(headroom_low),
  .ovp_cmp(ovp_cmp), .tsd_cmp(tsd_cmp), .boost_mode(boost_mode), .led_on(led_on),
  .flash_active(flash_active), .torch_active(torch_active),
  .therm_detect_on(therm_detect_on), .ilim_sel(ilim_sel), .monitor_thr_sel(monitor_thr_sel));

//--- verification/lffc_host.sv
// lffc_host: host model issuing register strobes as the serial slave would.
// assumes strobes are sampled on rising ref_clk; it drives on falling edges.
`timescale 1ns/1ps
module lffc_host (
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic reg_rd_done,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_rd_done = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // idle address and data are inverted so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    reg_rd_done = 1'b1;
    @(negedge ref_clk);
    reg_rd_done = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // lffc_host

//--- verification/tb.sv
// tb: self-checking bench for lffc_core with shortened time-out and deglitch counts.
// assumes the host model in lffc_host and the bound checker.
`timescale 1ns/1ps
module tb
  import lffc_pkg::*;
;
  localparam int TSTEP = 50;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} lffc_row_t;
  typedef struct packed {logic [3:0] i; logic [11:0] h; logic on; logic [7:0] a; logic [7:0] f;} lffc_flt_t;
  localparam lffc_row_t REGS [16] = '{'{0, 8'h01, 8'h00, 8'he0}, '{0, 8'h02, 8'h00, 8'ha4},
    '{0, 8'h03, 8'h00, 8'h20}, '{0, 8'h04, 8'h00, 8'h42}, '{0, 8'h07, 8'h00, 8'h7f},
    '{0, 8'h08, 8'h00, 8'h00}, '{0, 8'h09, 8'h00, 8'h30}, '{0, 8'h05, 8'h00, 8'h00},
    '{0, 8'h0a, 8'h00, 8'h00}, '{1, 8'h03, 8'h55, 8'h55}, '{1, 8'h08, 8'hff, 8'h00},
    '{1, 8'h09, 8'h00, 8'h20}, '{1, 8'h09, 8'h10, 8'h30}, '{1, 8'h07, 8'h05, 8'h05},
    '{1, 8'h02, 8'hb5, 8'hb5}, '{1, 8'h01, 8'ha0, 8'ha0}};
  // ovp, ilim, trip, short, open, lockout, tsd, led1, led2, vout; ovp short then long
  localparam lffc_flt_t FLTS [11] = '{'{0, 10, 1, 8'h08, 8'h00}, '{0, 40, 0, 8'h08, 8'h80},
    '{1, 5, 1, 8'h08, 8'h10}, '{2, 10, 0, 8'h08, 8'h40}, '{3, 10, 0, 8'h09, 8'h32},
    '{4, 10, 0, 8'h09, 8'h31}, '{5, 10, 0, 8'h08, 8'h04}, '{6, 10, 0, 8'h08, 8'h20},
    '{7, 2600, 0, 8'h09, 8'h34}, '{8, 2600, 0, 8'h09, 8'h38}, '{9, 3100, 0, 8'h08, 8'h02}};
  logic ref_clk, reg_wr, reg_rd, reg_rd_done, boost_mode, led_on, flash_active, torch_active;
  logic rst = 1'b1;
  logic sync_pin = 1'b0;
  logic headroom_low = 1'b0;
  logic vin_below_thr = 1'b0;
  logic vin_above_hys = 1'b0;
  logic [9:0] flt = '0;
  logic [LEVEL_W-1:0] flash_target = 7'h04;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [LEVEL_W-1:0] led_level;
  logic therm_detect_on;
  logic [2:0] ilim_sel;
  logic [1:0] monitor_thr_sel, monitor_hys_sel;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  lffc_host host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  lffc_core #(.TIMEOUT_STEP_CYC(TSTEP), .OVP_CYC(20), .VOUT_SAMPLE_CYC(3000)) dut (
    .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .flash_target(flash_target), .sync_pin(sync_pin), .headroom_low(headroom_low),
    .vin_below_thr(vin_below_thr), .vin_above_hys(vin_above_hys), .ovp_cmp(flt[0]),
    .ilim_cmp(flt[1]), .therm_trip_cmp(flt[2]), .therm_short_cmp(flt[3]),
    .therm_open_cmp(flt[4]), .low_supply_lockout_cmp(flt[5]), .tsd_cmp(flt[6]), .led1_short_cmp(flt[7]),
    .led2_short_cmp(flt[8]), .vout_short_cmp(flt[9]), .boost_mode(boost_mode),
    .led_on(led_on), .led_level(led_level), .flash_active(flash_active),
    .torch_active(torch_active), .therm_detect_on(therm_detect_on), .ilim_sel(ilim_sel),
    .monitor_thr_sel(monitor_thr_sel), .monitor_hys_sel(monitor_hys_sel));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one flash; a flash longer than 120 cycles has the sync pin toggled mid-pulse, then held high into the time-out
  task automatic flash_run(input logic [2:0] sel, input logic [7:0] en);
    int exp;
    int n;
    exp = (int'(sel) + 1) * TSTEP;
    host.wr(ADDR_DURATION, {5'h08, sel});
    host.wr(ADDR_ENABLE, en);
    n = 0;
    while (flash_active !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    while (flash_active === 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
      case (n)
        100: begin
          check({1'b0, led_level}, 8'h04);
          sync_pin = 1'b1;
        end
        110: begin
          check({1'b0, led_level}, en[EN_SYNC] ? 8'h05 : 8'h04);
          sync_pin = 1'b0;
        end
        120: begin
          check({1'b0, led_level}, 8'h04);
          sync_pin = 1'b1;
          vin_below_thr = 1'b1;
        end
        125: vin_below_thr = 1'b0;
        default: ;
      endcase
    end
    @(negedge ref_clk);
    check({6'h0, led_on, flash_active}, 8'h00);
    check({7'h0, n >= exp - 2 && n <= exp + 2}, 8'h01);
    host.rd(ADDR_FLAGS1, rv);
    check(rv, sel == 3'h0 ? 8'h01 : 8'h09);
    host.rd(ADDR_ENABLE, rv);
    check(rv, en & 8'hfc);
    host.rd(ADDR_FLAGS1, rv);
    check(rv, 8'h00);
    sync_pin = 1'b0;
  endtask
  // torch with thermistor detection on, one fault input raised then released
  task automatic fault_run(input lffc_flt_t r);
    host.wr(ADDR_ENABLE, 8'hf2);
    repeat (4) @(negedge ref_clk);
    check({7'h0, therm_detect_on}, 8'h01);
    flt[r.i] = 1'b1;
    repeat (r.h) @(negedge ref_clk);
    flt = '0;
    check({7'h0, torch_active}, {7'h0, r.on});
    repeat (4) @(negedge ref_clk);
    host.wr(ADDR_ENABLE, 8'hf2);
    // torch enable bit must stay clear while the fault lock holds
    if (!r.on) begin
      host.wr(ADDR_TORCH, 8'h85);
      host.rd(ADDR_TORCH, rv);
      check(rv, 8'h05);
    end
    host.rd(ADDR_ENABLE, rv);
    check(rv, r.on ? 8'hf2 : 8'hf0);
    host.rd(r.a, rv);
    check(rv, r.f);
    host.rd(ADDR_FLAGS1, rv);
    host.rd(ADDR_FLAGS2, rv);
    host.wr(ADDR_ENABLE, 8'he0);
  endtask
  initial begin
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 20000) begin
        error_cnt++;
        end_sim;
      end
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({7'h0, boost_mode}, 8'h00);
    headroom_low = 1'b1;
    repeat (8) @(negedge ref_clk);
    check({7'h0, boost_mode}, 8'h00);
    foreach (REGS[i]) begin
      if (REGS[i].w) host.wr(REGS[i].a, REGS[i].d);
      host.rd(REGS[i].a, rv);
      check(rv, REGS[i].e);
    end
    check({5'h0, ilim_sel}, 8'h05);
    check({4'h0, monitor_thr_sel, monitor_hys_sel}, 8'h0a);
    host.wr(ADDR_ENABLE, 8'he1);
    repeat (5) @(negedge ref_clk);
    check({6'h0, flash_active, torch_active}, 8'h00);
    host.wr(ADDR_ENABLE, 8'he2);
    repeat (500) @(negedge ref_clk);
    check({6'h0, flash_active, torch_active}, 8'h01);
    check({7'h0, boost_mode}, 8'h01);
    host.wr(ADDR_ENABLE, 8'he0);
    flash_run(3'h7, 8'heb);
    flash_run(3'h3, 8'he3);
    flash_run(3'h0, 8'he3);
    // down mode then up-down mode on one long flash
    host.wr(ADDR_MONITOR, 8'hd5);
    host.wr(ADDR_DURATION, 8'h47);
    host.wr(ADDR_ENABLE, 8'he3);
    repeat (80) @(negedge ref_clk);
    check({1'b0, led_level}, 8'h04);
    vin_below_thr = 1'b1;
    repeat (5) @(negedge ref_clk);
    vin_below_thr = 1'b0;
    repeat (80) @(negedge ref_clk);
    check({1'b0, led_level}, 8'h00);
    vin_above_hys = 1'b1;
    repeat (5) @(negedge ref_clk);
    vin_above_hys = 1'b0;
    repeat (30) @(negedge ref_clk);
    check({1'b0, led_level}, 8'h00);
    host.wr(ADDR_MONITOR, 8'hf5);
    repeat (80) @(negedge ref_clk);
    check({1'b0, led_level}, 8'h04);
    repeat (150) @(negedge ref_clk);
    host.rd(ADDR_FLAGS1, rv);
    check(rv, 8'h09);
    foreach (FLTS[i]) fault_run(FLTS[i]);
    end_sim;
  end
endmodule // tb
